// File: hw/qdma_pkg.sv
// Shared constants for the queued 48-bit DMA read command ends.
package qdma_pkg;
    // Taskfile register offsets on the three-bit address.
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_FEATURES = 3'h1;
    localparam logic [2:0] ADDR_COUNT = 3'h2;
    localparam logic [2:0] ADDR_LBA_LOW = 3'h3;
    localparam logic [2:0] ADDR_LBA_MID = 3'h4;
    localparam logic [2:0] ADDR_LBA_HIGH = 3'h5;
    localparam logic [2:0] ADDR_DRIVE = 3'h6;
    localparam logic [2:0] ADDR_OPCODE = 3'h7;
    // Command codes.
    localparam logic [7:0] OP_READ_QUEUED_EXT = 8'h26;
    localparam logic [7:0] OP_SERVICE_DEFAULT = 8'hA2;
    // Field positions.
    localparam int TAG_LSB = 3;
    localparam int FLAG_REL = 2;
    localparam int FLAG_IO = 1;
    localparam int FLAG_CD = 0;
    localparam int DRIVE_LBA = 6;
    localparam int DRIVE_DEV = 4;
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DF = 5;
    localparam int ST_SERV = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ERR_ABRT = 2;
    // Number of two-level registers, features through block_addr_high.
    localparam int TWO_LEVEL_COUNT = 5;
    // Reset values.
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Count of writes that deliver one command from the host.
    localparam int HOST_WRITES = 12;
endpackage

// File: hw/queued_read_device.sv
// Device end: decodes the queued 48-bit DMA read and drives its outputs.

// Notes on behaviour
// - Opcode 26h starts the queued DMA read.
// - Supported with overlapped and 48-bit sets.
// - Refused when packet command set present.
// - Count is previous and current features bytes.
// - Zero count means 65,536 sectors.
// - Tag taken from current count bits 7:3.
// - Every tag 0 through 31 accepted.
// - Host writes zero tag without queuing.
// - Address built from previous and current bytes.
// - Features through LBA high keep two bytes each; drive keeps one.
// - Host sets the addressing bit 6.
// - Drive bit selects device, reads back selection.
// - Data starts at once or after service.
// - Data phase flags: REL 0, IO 1, CD 0.
// - Tag returned in count register, HOB clear.
// - Tag reads zero without queuing or overlap.
// - Other taskfile reads return reserved zero.
// - Data phase status: only ready bit set.
// - After release, readiness sets only service.
// - Release before data sets the REL flag.
module queued_read_device #(
    parameter logic DEVICE_NUM = 1'b0,
    parameter bit HAS_OVERLAP_SET = 1'b1,
    parameter bit HAS_ADDR48_SET = 1'b1,
    parameter bit HAS_PACKET_SET = 1'b0,
    parameter logic [7:0] OP_SERVICE = qdma_pkg::OP_SERVICE_DEFAULT
) (
    input wire logic clk,
    input wire logic sys_rst,
    taskfile_if.device tf,
    input wire logic queuing_supported,
    input wire logic overlap_enabled,
    input wire logic data_ready,
    input wire logic bus_release,
    input wire logic service_ready,
    input wire logic transfer_done,
    output logic cmd_start,
    output logic [47:0] cmd_lba,
    output logic [16:0] cmd_count,
    output logic [4:0] cmd_tag,
    output logic cmd_active
);
    typedef enum logic [2:0] {
        st_idle,
        st_busy,
        st_released,
        st_data,
        st_done
    } dev_state_type;

    dev_state_type state, next_state;
    logic [7:0] cur [qdma_pkg::TWO_LEVEL_COUNT];
    logic [7:0] prev [qdma_pkg::TWO_LEVEL_COUNT];
    logic [7:0] drive, next_drive;
    logic serv, next_serv;
    logic aborted, next_aborted;
    logic next_start;
    logic [47:0] next_lba;
    logic [16:0] next_count;
    logic [4:0] next_tag;
    logic [7:0] next_rdata;
    logic next_rvalid;
    logic opcode_wr;
    logic selected;
    logic supported;
    logic tag_valid;
    logic [7:0] status;
    logic [7:0] flags;
    logic [7:0] tag_byte;

    // Two-level storage for features through block_addr_high.
    // keep both bytes
    for (genvar i = 0; i < qdma_pkg::TWO_LEVEL_COUNT; i++) begin : g_lvl
        two_level_reg u_reg (
            .clk(clk),
            .sys_rst(sys_rst),
            .wr(tf.tf_wr && tf.tf_addr == qdma_pkg::ADDR_FEATURES + 3'(i)),
            .wdata(tf.tf_wdata),
            .cur(cur[i]),
            .prev(prev[i])
        );
    end

    // Decode terms for the state logic, plus the cmd_active output.
    // device select match
    assign selected = drive[qdma_pkg::DRIVE_DEV] == DEVICE_NUM;
    assign opcode_wr = tf.tf_wr && tf.tf_addr == qdma_pkg::ADDR_OPCODE;
    assign supported = HAS_OVERLAP_SET && HAS_ADDR48_SET &&
        !HAS_PACKET_SET && overlap_enabled;
    assign tag_valid = queuing_supported && overlap_enabled;
    assign cmd_active = state != st_idle && state != st_done;

    // Status and count-register flags for each phase of the command.
    always_comb begin
        status = 8'h00;
        flags = 8'h00;
        case (state)
            st_idle: begin
                status[qdma_pkg::ST_DRDY] = 1'b1;
                status[qdma_pkg::ST_ERR] = aborted;
            end
            st_busy: begin
                status[qdma_pkg::ST_BSY] = 1'b1;
            end
            st_released: begin
                flags[qdma_pkg::FLAG_REL] = 1'b1;
                status[qdma_pkg::ST_DRDY] = 1'b1;
                status[qdma_pkg::ST_SERV] = serv;
            end
            st_data: begin
                flags[qdma_pkg::FLAG_IO] = 1'b1;
                status[qdma_pkg::ST_DRDY] = 1'b1;
            end
            default: begin
                flags[qdma_pkg::FLAG_IO] = 1'b1;
                flags[qdma_pkg::FLAG_CD] = 1'b1;
                status[qdma_pkg::ST_DRDY] = 1'b1;
            end
        endcase
        tag_byte = {cmd_tag, 3'h0} | flags;
    end

    // Command acceptance, phase sequencing and the read path.
    always_comb begin
        next_state = state;
        next_drive = drive;
        next_serv = serv;
        next_aborted = aborted;
        next_start = 1'b0;
        next_lba = cmd_lba;
        next_count = cmd_count;
        next_tag = cmd_tag;
        next_rdata = tf.tf_rdata;
        next_rvalid = 1'b0;
        if (tf.tf_wr && tf.tf_addr == qdma_pkg::ADDR_DRIVE) begin
            next_drive = tf.tf_wdata;
        end
        case (state)
            st_idle, st_done: begin
                if (opcode_wr && selected) begin
                    if (tf.tf_wdata == qdma_pkg::OP_READ_QUEUED_EXT &&
                        supported) begin
                        next_state = st_busy;
                        next_aborted = 1'b0;
                        next_serv = 1'b0;
                        next_start = 1'b1;
                        next_lba = {prev[4], prev[3], prev[2],
                            cur[4], cur[3], cur[2]};
                        next_count = {prev[0], cur[0]} == 16'h0000 ?
                            17'h10000 : {1'b0, prev[0], cur[0]};
                        next_tag = tag_valid ?
                            cur[1][7:qdma_pkg::TAG_LSB] : 5'h00;
                    end else begin
                        next_state = st_idle;
                        next_aborted = 1'b1;
                    end
                end
            end
            st_busy: begin
                if (data_ready) begin
                    next_state = st_data;
                end else if (bus_release) begin
                    next_state = st_released;
                end
            end
            st_released: begin
                if (service_ready) begin
                    next_serv = 1'b1;
                end
                if (opcode_wr && selected && serv &&
                    tf.tf_wdata == OP_SERVICE) begin
                    next_state = st_data;
                    next_serv = 1'b0;
                end
            end
            st_data: begin
                if (transfer_done) begin
                    next_state = st_done;
                end
            end
            default: begin
                next_state = st_idle;
            end
        endcase
        if (tf.tf_rd) begin
            next_rvalid = 1'b1;
            next_rdata = 8'h00;
            if (tf.tf_addr == qdma_pkg::ADDR_OPCODE) begin
                next_rdata = status;
            end else if (tf.tf_addr == qdma_pkg::ADDR_DRIVE) begin
                next_rdata[qdma_pkg::DRIVE_DEV] = drive[qdma_pkg::DRIVE_DEV];
            end else if (tf.tf_addr == qdma_pkg::ADDR_FEATURES) begin
                next_rdata[qdma_pkg::ERR_ABRT] = aborted;
            end else if (tf.tf_addr == qdma_pkg::ADDR_COUNT && !tf.hob &&
                state != st_idle) begin
                next_rdata = tag_byte;
            end
        end
    end

    // Register stage for all control and answer state.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= st_idle;
            drive <= qdma_pkg::RESET_BYTE;
            serv <= 1'b0;
            aborted <= 1'b0;
            cmd_start <= 1'b0;
            cmd_lba <= 48'h000000000000;
            cmd_count <= 17'h00000;
            cmd_tag <= 5'h00;
            tf.tf_rdata <= qdma_pkg::RESET_BYTE;
            tf.tf_rvalid <= 1'b0;
        end else begin
            state <= next_state;
            drive <= next_drive;
            serv <= next_serv;
            aborted <= next_aborted;
            cmd_start <= next_start;
            cmd_lba <= next_lba;
            cmd_count <= next_count;
            cmd_tag <= next_tag;
            tf.tf_rdata <= next_rdata;
            tf.tf_rvalid <= next_rvalid;
        end
    end
endmodule

// File: hw/queued_read_host.sv
// Host adapter end: writes the taskfile sequence and reads registers.
module queued_read_host #(
    parameter logic [7:0] OP_SERVICE = qdma_pkg::OP_SERVICE_DEFAULT
) (
    input wire logic clk,
    input wire logic sys_rst,
    taskfile_if.host tf,
    input wire logic queuing_supported,
    input wire logic cmd_req,
    input wire logic [47:0] cmd_lba,
    input wire logic [15:0] cmd_count,
    input wire logic [4:0] cmd_tag,
    input wire logic cmd_dev,
    input wire logic svc_req,
    input wire logic rd_req,
    input wire logic [2:0] rd_addr,
    input wire logic hob_sel,
    output logic host_ready,
    output logic rd_valid,
    output logic [7:0] rd_data
);
    typedef enum logic [1:0] {
        hs_idle,
        hs_write,
        hs_read
    } host_state_type;

    host_state_type state, next_state;
    logic [3:0] step, next_step;
    logic [47:0] lba, next_lba;
    logic [15:0] count, next_count;
    logic [4:0] tag, next_tag;
    logic dev, next_dev;
    logic svc_only, next_svc_only;
    logic next_wr, next_rd;
    logic [2:0] next_addr;
    logic [7:0] next_wdata;
    logic [7:0] next_rd_data;
    logic next_rd_valid;
    logic [7:0] drive_byte;

    assign host_ready = state == hs_idle;

    // Byte for each write, previous level first, opcode last.
    always_comb begin
        drive_byte = 8'h00;
        drive_byte[qdma_pkg::DRIVE_LBA] = 1'b1;
        drive_byte[qdma_pkg::DRIVE_DEV] = dev;
        next_addr = qdma_pkg::ADDR_OPCODE;
        next_wdata = svc_only ? OP_SERVICE : qdma_pkg::OP_READ_QUEUED_EXT;
        case (step)
            4'h0: {next_addr, next_wdata} = {qdma_pkg::ADDR_FEATURES,
                count[15:8]};
            4'h1: {next_addr, next_wdata} = {qdma_pkg::ADDR_FEATURES,
                count[7:0]};
            4'h2: {next_addr, next_wdata} = {qdma_pkg::ADDR_COUNT, 8'h00};
            4'h3: {next_addr, next_wdata} = {qdma_pkg::ADDR_COUNT, tag, 3'h0};
            4'h4: {next_addr, next_wdata} = {qdma_pkg::ADDR_LBA_LOW,
                lba[31:24]};
            4'h5: {next_addr, next_wdata} = {qdma_pkg::ADDR_LBA_LOW,
                lba[7:0]};
            4'h6: {next_addr, next_wdata} = {qdma_pkg::ADDR_LBA_MID,
                lba[39:32]};
            4'h7: {next_addr, next_wdata} = {qdma_pkg::ADDR_LBA_MID,
                lba[15:8]};
            4'h8: {next_addr, next_wdata} = {qdma_pkg::ADDR_LBA_HIGH,
                lba[47:40]};
            4'h9: {next_addr, next_wdata} = {qdma_pkg::ADDR_LBA_HIGH,
                lba[23:16]};
            4'hA: {next_addr, next_wdata} = {qdma_pkg::ADDR_DRIVE,
                drive_byte};
            default: begin
            end
        endcase
    end

    // Sequencer: one taskfile access per cycle, reads wait for the answer.
    always_comb begin
        next_state = state;
        next_step = step;
        next_lba = lba;
        next_count = count;
        next_tag = tag;
        next_dev = dev;
        next_svc_only = svc_only;
        next_wr = 1'b0;
        next_rd = 1'b0;
        next_rd_valid = 1'b0;
        next_rd_data = rd_data;
        case (state)
            hs_idle: begin
                if (cmd_req) begin
                    next_state = hs_write;
                    next_step = 4'h0;
                    next_lba = cmd_lba;
                    next_count = cmd_count;
                    next_tag = queuing_supported ? cmd_tag : 5'h00;
                    next_dev = cmd_dev;
                    next_svc_only = 1'b0;
                end else if (svc_req) begin
                    next_state = hs_write;
                    next_step = 4'(qdma_pkg::HOST_WRITES - 1);
                    next_svc_only = 1'b1;
                end else if (rd_req) begin
                    next_state = hs_read;
                    next_rd = 1'b1;
                end
            end
            hs_write: begin
                next_wr = 1'b1;
                if (step == 4'(qdma_pkg::HOST_WRITES - 1)) begin
                    next_state = hs_idle;
                end else begin
                    next_step = step + 4'h1;
                end
            end
            default: begin
                if (tf.tf_rvalid) begin
                    next_state = hs_idle;
                    next_rd_valid = 1'b1;
                    next_rd_data = tf.tf_rdata;
                end
            end
        endcase
    end

    // Register stage; taskfile pins come straight from flip-flops.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= hs_idle;
            step <= 4'h0;
            lba <= 48'h000000000000;
            count <= 16'h0000;
            tag <= 5'h00;
            dev <= 1'b0;
            svc_only <= 1'b0;
            tf.tf_wr <= 1'b0;
            tf.tf_rd <= 1'b0;
            tf.tf_addr <= qdma_pkg::ADDR_DATA;
            tf.tf_wdata <= qdma_pkg::RESET_BYTE;
            tf.hob <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= qdma_pkg::RESET_BYTE;
        end else begin
            state <= next_state;
            step <= next_step;
            lba <= next_lba;
            count <= next_count;
            tag <= next_tag;
            dev <= next_dev;
            svc_only <= next_svc_only;
            tf.tf_wr <= next_wr;
            tf.tf_rd <= next_rd;
            tf.tf_addr <= next_rd ? rd_addr : next_addr;
            tf.tf_wdata <= next_wdata;
            tf.hob <= hob_sel;
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
        end
    end
endmodule

// File: hw/taskfile_if.sv
// Taskfile access channel between host adapter and device.
interface taskfile_if;
    logic tf_wr;
    logic tf_rd;
    logic [2:0] tf_addr;
    logic [7:0] tf_wdata;
    logic [7:0] tf_rdata;
    logic tf_rvalid;
    logic hob;

    modport device (
        input tf_wr,
        input tf_rd,
        input tf_addr,
        input tf_wdata,
        input hob,
        output tf_rdata,
        output tf_rvalid
    );
    modport host (
        output tf_wr,
        output tf_rd,
        output tf_addr,
        output tf_wdata,
        output hob,
        input tf_rdata,
        input tf_rvalid
    );
endinterface

// File: hw/two_level_reg.sv
// One taskfile register that keeps its current and previous byte.
module two_level_reg (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] cur,
    output logic [7:0] prev
);
    logic [7:0] next_cur;
    logic [7:0] next_prev;

    // Each write pushes the old current byte down one level.
    always_comb begin
        next_cur = cur;
        next_prev = prev;
        if (wr) begin
            next_cur = wdata;
            next_prev = cur;
        end
    end

    // Register stage.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur <= qdma_pkg::RESET_BYTE;
            prev <= qdma_pkg::RESET_BYTE;
        end else begin
            cur <= next_cur;
            prev <= next_prev;
        end
    end
endmodule

// File: tb/queued_dma_read_ext_command_test.sv
// Self-checking bench joining the host and device ends of the read command.
module queued_dma_read_ext_command_test;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [47:0] lba;
        logic [15:0] cnt;
        logic [4:0] tag;
        logic [16:0] want;
    } row_type;
    // Ordinary commands with the count each should decode to.
    row_type rows [4] = '{
        '{48'h123456789ABC, 16'h0000, 5'h00, 17'h10000},
        '{48'hFFFFFFFFFFFF, 16'hFFFF, 5'h1F, 17'h0FFFF},
        '{48'h000000000001, 16'h0001, 5'h11, 17'h00001},
        '{48'h800000000000, 16'h0100, 5'h01, 17'h00100}};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic queuing_supported, overlap_enabled, data_ready, bus_release;
    logic service_ready, transfer_done, cmd_req, svc_req, rd_req, hob_sel;
    logic cmd_dev, host_ready, rd_valid, d_start, d_active;
    logic [47:0] h_lba, d_lba;
    logic [15:0] h_count;
    logic [16:0] d_count;
    logic [4:0] h_tag, d_tag;
    logic [2:0] rd_addr;
    logic [7:0] rd_data;
    int n_fail = 0;
    int cmp_count = 0;

    taskfile_if tf_bus ();
    queued_read_host i_queued_read_host (.clk(clk), .sys_rst(sys_rst),
        .tf(tf_bus), .queuing_supported(queuing_supported),
        .cmd_req(cmd_req), .cmd_lba(h_lba), .cmd_count(h_count),
        .cmd_tag(h_tag), .cmd_dev(cmd_dev), .svc_req(svc_req),
        .rd_req(rd_req), .rd_addr(rd_addr), .hob_sel(hob_sel),
        .host_ready(host_ready), .rd_valid(rd_valid), .rd_data(rd_data));
    queued_read_device i_queued_read_device (.clk(clk), .sys_rst(sys_rst),
        .tf(tf_bus), .queuing_supported(queuing_supported),
        .overlap_enabled(overlap_enabled), .data_ready(data_ready),
        .bus_release(bus_release), .service_ready(service_ready),
        .transfer_done(transfer_done), .cmd_start(d_start),
        .cmd_lba(d_lba), .cmd_count(d_count), .cmd_tag(d_tag),
        .cmd_active(d_active));
    queued_read_checker i_queued_read_checker (.clk(clk), .sys_rst(sys_rst),
        .tf_wr(tf_bus.tf_wr), .tf_rd(tf_bus.tf_rd), .tf_addr(tf_bus.tf_addr),
        .tf_wdata(tf_bus.tf_wdata), .tf_rdata(tf_bus.tf_rdata),
        .tf_rvalid(tf_bus.tf_rvalid), .hob(tf_bus.hob),
        .queuing_supported(queuing_supported),
        .overlap_enabled(overlap_enabled), .cmd_start(d_start),
        .cmd_lba(d_lba), .cmd_count(d_count), .cmd_tag(d_tag),
        .cmd_active(d_active));

    // Free-running 100 MHz clock.
    initial begin
        forever #5 clk = ~clk;
    end

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [47:0] seen, input logic [47:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    // Host requests are only taken while it is idle, so send and rd wait for it first.
    task automatic wait_ready();
        for (int i = 0; i < 40; i++) begin
            if (host_ready === 1'b1) begin
                return;
            end
            @(negedge clk);
        end
        n_fail++;
        test_done();
    endtask

    task automatic send(input logic [47:0] lba, input logic [15:0] cnt,
            input logic [4:0] tag, input logic dev);
        wait_ready();
        h_lba = lba;
        h_count = cnt;
        h_tag = tag;
        cmd_dev = dev;
        cmd_req = 1'b1;
        @(negedge clk);
        cmd_req = 1'b0;
    endtask

    // A refused command must stay silent for the whole window.
    task automatic wait_start(input logic want);
        logic got;
        got = 1'b0;
        for (int i = 0; i < 40 && !got; i++) begin
            @(negedge clk);
            got = d_start;
        end
        check(got, want);
        if (want && !got) begin
            test_done();
        end
    endtask

    task automatic rd(input logic [2:0] addr, input logic h,
            input logic [7:0] want);
        wait_ready();
        hob_sel = h;
        @(negedge clk);
        rd_addr = addr;
        rd_req = 1'b1;
        @(negedge clk);
        rd_req = 1'b0;
        for (int i = 0; i < 8 && rd_valid !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (rd_valid !== 1'b1) begin
            n_fail++;
            test_done();
        end
        check(rd_data, want);
    endtask

    // Bits: data ready, bus release, service ready, transfer done.
    task automatic pulse(input logic [3:0] sel);
        {data_ready, bus_release, service_ready, transfer_done} = sel;
        @(negedge clk);
        {data_ready, bus_release, service_ready, transfer_done} = 4'h0;
        @(negedge clk);
    endtask

    // Guard against a hang anywhere in the sequence.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        test_done();
    end

    initial begin
        {cmd_req, svc_req, rd_req, hob_sel, cmd_dev} = 5'h00;
        {data_ready, bus_release, service_ready, transfer_done} = 4'h0;
        {queuing_supported, overlap_enabled} = 2'h3;
        {h_lba, h_count, h_tag, rd_addr} = 72'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            send(rows[i].lba, rows[i].cnt, rows[i].tag, 1'b0);
            wait_start(1'b1);
            check(d_lba, rows[i].lba);
            check(d_count, rows[i].want);
            check(d_tag, rows[i].tag);
            rd(qdma_pkg::ADDR_OPCODE, 1'b0, 8'h80);
            pulse(4'h8);
            rd(qdma_pkg::ADDR_COUNT, 1'b0, {rows[i].tag, 3'h2});
            rd(qdma_pkg::ADDR_OPCODE, 1'b0, 8'h40);
            pulse(4'h1);
        end
        // A second command while busy must not disturb the running one.
        send(48'hA5A5A5A5A5A5, 16'h0042, 5'h0A, 1'b0);
        wait_start(1'b1);
        send(48'h5A5A5A5A5A5A, 16'h0007, 5'h03, 1'b0);
        wait_start(1'b0);
        check(d_lba, 48'hA5A5A5A5A5A5);
        check(d_count, 17'h00042);
        // Release, service request, then the service opcode resumes data.
        pulse(4'h4);
        rd(qdma_pkg::ADDR_COUNT, 1'b0, 8'h54);
        rd(qdma_pkg::ADDR_OPCODE, 1'b0, 8'h40);
        pulse(4'h2);
        rd(qdma_pkg::ADDR_OPCODE, 1'b0, 8'h50);
        rd(qdma_pkg::ADDR_COUNT, 1'b0, 8'h54);
        wait_ready();
        svc_req = 1'b1;
        @(negedge clk);
        svc_req = 1'b0;
        rd(qdma_pkg::ADDR_COUNT, 1'b0, 8'h52);
        rd(qdma_pkg::ADDR_COUNT, 1'b1, 8'h00);
        rd(qdma_pkg::ADDR_LBA_LOW, 1'b0, 8'h00);
        pulse(4'h1);
        // Opcode for the other drive is ignored but the select bit echoes.
        send(48'h000000000010, 16'h0001, 5'h02, 1'b1);
        wait_start(1'b0);
        rd(qdma_pkg::ADDR_DRIVE, 1'b0, 8'h10);
        // Without queuing the tag is dropped on both ends.
        queuing_supported = 1'b0;
        send(48'h000000000020, 16'h0002, 5'h09, 1'b0);
        wait_start(1'b1);
        check(d_tag, 5'h00);
        pulse(4'h8);
        rd(qdma_pkg::ADDR_COUNT, 1'b0, 8'h02);
        pulse(4'h1);
        queuing_supported = 1'b1;
        // Overlap disabled makes the command abort.
        overlap_enabled = 1'b0;
        send(48'h000000000030, 16'h0003, 5'h04, 1'b0);
        wait_start(1'b0);
        rd(qdma_pkg::ADDR_OPCODE, 1'b0, 8'h41);
        rd(qdma_pkg::ADDR_FEATURES, 1'b0, 8'h04);
        overlap_enabled = 1'b1;
        // Reset in mid-run returns both ends to idle.
        sys_rst = 1'b1;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        check(d_active, 1'b0);
        check(host_ready, 1'b1);
        rd(qdma_pkg::ADDR_OPCODE, 1'b0, 8'h40);
        rd(qdma_pkg::ADDR_FEATURES, 1'b0, 8'h00);
        test_done();
    end
endmodule

// File: tb/queued_read_checker.sv
// Concurrent checks on the taskfile channel and the decoded read command.
module queued_read_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tf_wr,
    input wire logic tf_rd,
    input wire logic [2:0] tf_addr,
    input wire logic [7:0] tf_wdata,
    input wire logic [7:0] tf_rdata,
    input wire logic tf_rvalid,
    input wire logic hob,
    input wire logic queuing_supported,
    input wire logic overlap_enabled,
    input wire logic cmd_start,
    input wire logic [47:0] cmd_lba,
    input wire logic [16:0] cmd_count,
    input wire logic [4:0] cmd_tag,
    input wire logic cmd_active
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cur [1:6];
    logic [7:0] prev [1:6];
    logic [7:0] next_cur [1:6];
    logic [7:0] next_prev [1:6];
    logic [16:0] want_count;
    logic [47:0] want_lba;
    logic [4:0] tag_in;
    logic op_seen;
    logic drv_bit;

    // Own shadow of the two-level registers, independent of the device.
    always_comb begin
        next_cur = cur;
        next_prev = prev;
        if (tf_wr && tf_addr != 3'h0 && tf_addr != 3'h7) begin
            next_prev[tf_addr] = cur[tf_addr];
            next_cur[tf_addr] = tf_wdata;
        end
    end

    // Shadow registers clear with the device so both start from zero bytes.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur <= '{default: 8'h00};
            prev <= '{default: 8'h00};
        end else begin
            cur <= next_cur;
            prev <= next_prev;
        end
    end

    // Expected command fields; a zero count stands for the largest transfer.
    always_comb begin
        want_count = {1'b0, prev[1], cur[1]};
        if (want_count == 17'h00000) begin
            want_count = 17'h10000;
        end
        want_lba = {prev[5], prev[4], prev[3], cur[5], cur[4], cur[3]};
    end

    // Tag is only meaningful with queuing and overlap both on.
    assign tag_in = (queuing_supported && overlap_enabled) ?
        cur[2][7:3] : 5'h00;
    assign op_seen = tf_wr && tf_addr == qdma_pkg::ADDR_OPCODE
        && tf_wdata == qdma_pkg::OP_READ_QUEUED_EXT;
    assign drv_bit = cur[6][qdma_pkg::DRIVE_DEV];

    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    chk_read_answer: assert property (tf_rd |=> tf_rvalid)
        else $error("read strobe not answered one cycle later");
    chk_valid_cause: assert property (tf_rvalid |-> $past(tf_rd))
        else $error("read answer without a read strobe");
    chk_opcode_start: assert property (
        cmd_start |-> $past(op_seen))
        else $error("command started without its opcode write");
    chk_start_pulse: assert property (
        cmd_start |-> cmd_active ##1 !cmd_start)
        else $error("start pulse wrong or device not active");
    chk_count_pair: assert property (
        cmd_start |-> cmd_count == $past(want_count))
        else $error("transfer count not built from two count bytes");
    chk_lba_pair: assert property (
        cmd_start |-> cmd_lba == $past(want_lba))
        else $error("block address not built from six bytes");
    chk_tag_capture: assert property (
        cmd_start |-> cmd_tag == $past(tag_in))
        else $error("captured tag wrong");
    chk_params_frozen: assert property (
        !cmd_start |-> $stable(cmd_lba) && $stable(cmd_count)
            && $stable(cmd_tag))
        else $error("command fields changed without a new command");
    chk_reserved_read: assert property (
        tf_rd && (tf_addr inside {3'h0, 3'h3, 3'h4, 3'h5}
            || (hob && tf_addr == 3'h2)) |=> tf_rdata == 8'h00)
        else $error("reserved register read not zero");
    chk_drive_echo: assert property (
        tf_rd && tf_addr == 3'h6 |=> tf_rdata == {3'h0, $past(drv_bit), 4'h0})
        else $error("drive register does not echo the select bit");

    cover property (cmd_start && cmd_count == 17'h10000);
    cover property (cmd_start && cmd_tag == 5'h1F);
    cover property (tf_rvalid && tf_rdata == 8'h50);
endmodule
